// ### hw/clr_regs.svh
// constants of the camera link receiver and region monitor
`ifndef CLR_REGS_SVH
`define CLR_REGS_SVH
// positions inside the rebuilt 28-bit camera word
`define CLR_WORD_W 28
`define CLR_LANES 4
`define CLR_LANE_BITS 7
`define CLR_IMG_LSB 0
`define CLR_IMG_W 24
`define CLR_LVAL_BIT 24
`define CLR_FVAL_BIT 25
`define CLR_DVAL_BIT 26
// pixel shift selections and their shift amounts
`define CLR_SHIFT_8BIT 2'h0
`define CLR_SHIFT_10BIT 2'h1
`define CLR_SHIFT_12BIT 2'h2
`define CLR_SHAMT_10BIT 3'h2
`define CLR_SHAMT_12BIT 3'h4
// message link read selections
`define CLR_MSG_PIX_TOTAL 3'h0
`define CLR_MSG_LINE_TOTAL 3'h1
`define CLR_MSG_FIRST_PIX 3'h2
`define CLR_MSG_LAST_PIX 3'h3
`define CLR_MSG_FIRST_LINE 3'h4
`define CLR_MSG_LAST_LINE 3'h5
`define CLR_MSG_STATUS 3'h6
// default values
`define CLR_FIFO_DEPTH 8
`define CLR_DARK_DEFAULT 8'h10
`endif

// ### hw/clr_pkg.sv
// types of the camera link receiver and region monitor
package clr_pkg;
	typedef enum logic [1:0] {CLR_ITEM_PIX, CLR_ITEM_EOL, CLR_ITEM_EOF} clr_kind_t;
	typedef struct packed {
		clr_kind_t kind;
		logic [23:0] pix;
	} clr_item_t;
	typedef enum logic {CLR_PH_LOAD, CLR_PH_RISE} clr_phase_t;
endpackage : clr_pkg

// ### hw/clr_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module clr_fifo #(
	parameter int W = 26,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule : clr_fifo
`default_nettype wire

// ### hw/clr_top.sv
// camera link base receiver with pixel stream output and region monitor
// Function
// - rebuild the 28-bit camera word from four 7-bit lanes each camera clock
// - image bits go to the low 24 output bits, top byte zero
// - recover data valid, line valid and frame valid from the word
// - emit pixel valid, end of line, end of frame and a pixel clock
// - right shift pixels by 0, 2 or 4 bits per camera depth
// - low or high frequency input variant chosen at build time
// - count valid pixels per line and lines per frame
// - find first and last active pixel and line around dark borders
// - all six measurements readable over the message link
// - end of line or end of frame for one pixel clock after last pixel
// - at most one of the three strobes high at any pixel clock edge
`timescale 1ns/1ns
`default_nettype none
`include "clr_regs.svh"
module clr_top import clr_pkg::*; #(
	parameter bit HIGH_FREQ = 1'b0,
	parameter int CW = 16,
	parameter int DEPTH = `CLR_FIFO_DEPTH
) (
	// system clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// camera side, lanes already sliced into 7-bit groups per camera clock
	input wire logic cam_clk,
	input wire logic [3:0][6:0] cam_lane,
	// pixel stream out
	input wire logic stream_hold,
	output logic pixel_clock,
	output logic dvalid_out,
	output logic eol_out,
	output logic eof_out,
	output logic [31:0] data_out,
	output logic lost_word,
	// configuration
	input wire logic [1:0] shift_sel,
	input wire logic [7:0] dark_level,
	input wire logic roi_restart,
	// message control link read port
	input wire logic [2:0] msg_sel,
	output logic [CW-1:0] msg_data
);
	function automatic logic [2:0] shift_amount(input logic [1:0] sel);
		if (sel == `CLR_SHIFT_10BIT) begin
			return `CLR_SHAMT_10BIT;
		end else if (sel == `CLR_SHIFT_12BIT) begin
			return `CLR_SHAMT_12BIT;
		end
		return 3'h0;
	endfunction : shift_amount

	// camera clock domain
	logic rst_meta_q;
	logic rst_sync_q;
	logic [3:0][6:0] lane_q;
	logic [3:0][6:0] lane_use;
	logic [27:0] word_d;
	logic [27:0] word_q;
	logic lval_prev_q;
	logic pend_q;
	logic req_tgl_q;
	clr_item_t hold_q;
	logic cam_pix;
	logic lval;
	logic fval;

	// reset enters the camera domain through two flops
	always_ff @(posedge cam_clk) begin
		rst_meta_q <= sys_rst;
		rst_sync_q <= rst_meta_q;
	end

	always_ff @(posedge cam_clk) begin
		lane_q <= cam_lane;
	end

	// extra retiming stage eases timing for fast cameras at one clock of latency
	generate
		if (HIGH_FREQ) begin : g_hf
			logic [3:0][6:0] lane2_q;
			always_ff @(posedge cam_clk) begin
				lane2_q <= lane_q;
			end
			assign lane_use = lane2_q;
		end else begin : g_lf
			assign lane_use = lane_q;
		end
	endgenerate

	// first serial bit of each lane is its word lsb
	for (genvar l = 0; l < `CLR_LANES; l++) begin : g_lane
		for (genvar b = 0; b < `CLR_LANE_BITS; b++) begin : g_bit
			assign word_d[l*`CLR_LANE_BITS+b] = lane_use[l][`CLR_LANE_BITS-1-b];
		end
	end

	always_ff @(posedge cam_clk) begin
		word_q <= word_d;
	end

	assign lval = word_q[`CLR_LVAL_BIT];
	assign fval = word_q[`CLR_FVAL_BIT];
	assign cam_pix = word_q[`CLR_DVAL_BIT] && lval && fval;

	// a finished line is resolved one word later: frame valid tells eol from eof
	// limitation: a pixel in the word right after a line end is dropped
	always_ff @(posedge cam_clk) begin
		if (rst_sync_q) begin
			lval_prev_q <= 1'b0;
			pend_q <= 1'b0;
			req_tgl_q <= 1'b0;
			hold_q <= '0;
		end else begin
			lval_prev_q <= lval;
			if (pend_q) begin
				pend_q <= 1'b0;
				hold_q.kind <= fval ? CLR_ITEM_EOL : CLR_ITEM_EOF;
				hold_q.pix <= '0;
				req_tgl_q <= !req_tgl_q;
			end else if (lval_prev_q && !lval) begin
				pend_q <= 1'b1;
			end else if (cam_pix) begin
				hold_q.kind <= CLR_ITEM_PIX;
				hold_q.pix <= word_q[`CLR_IMG_LSB +: `CLR_IMG_W];
				req_tgl_q <= !req_tgl_q;
			end
		end
	end

	chk_word_rebuild: assert property (@(posedge cam_clk) disable iff (rst_sync_q)
		(cam_pix && !pend_q && !(lval_prev_q && !lval)) |=>
		(hold_q.pix == $past(word_q[23:0])) && (req_tgl_q != $past(req_tgl_q)))
		else $error("pixel word not passed on");
	chk_frame_end: assert property (@(posedge cam_clk) disable iff (rst_sync_q)
		(pend_q && !fval) |=> (hold_q.kind == CLR_ITEM_EOF))
		else $error("frame end not marked");

	// system clock domain: toggle crossing, held item is stable for a camera clock
	logic req_meta_q;
	logic req_sync_q;
	logic req_seen_q;
	logic new_item;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	clr_item_t fifo_out;
	logic pop;
	clr_phase_t phase_q;
	logic [2:0] shamt;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			req_meta_q <= 1'b0;
			req_sync_q <= 1'b0;
			req_seen_q <= 1'b0;
		end else begin
			req_meta_q <= req_tgl_q;
			req_sync_q <= req_meta_q;
			req_seen_q <= req_sync_q;
		end
	end

	assign new_item = req_sync_q ^ req_seen_q;

	clr_fifo #(
		.W($bits(clr_item_t)),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(new_item),
		.in_ready(fifo_in_ready),
		.in_data(hold_q),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out)
	);

	// the camera cannot be paused, so a full buffer drops the word and says so
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lost_word <= 1'b0;
		end else if (new_item && !fifo_in_ready) begin
			lost_word <= 1'b1;
		end
	end

	// output stage: strobes change with pixel clock low, sampled on its rise
	assign fifo_out_ready = (phase_q == CLR_PH_LOAD) && !stream_hold;
	assign pop = fifo_out_ready && fifo_out_valid;
	assign shamt = shift_amount(shift_sel);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			phase_q <= CLR_PH_LOAD;
			pixel_clock <= 1'b0;
		end else begin
			case (phase_q)
				CLR_PH_LOAD: begin
					phase_q <= CLR_PH_RISE;
				end
				default: begin
					phase_q <= CLR_PH_LOAD;
				end
			endcase
			pixel_clock <= (phase_q == CLR_PH_RISE);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dvalid_out <= 1'b0;
			eol_out <= 1'b0;
			eof_out <= 1'b0;
			data_out <= '0;
		end else if (phase_q == CLR_PH_LOAD) begin
			// one item per pixel clock keeps the strobes exclusive
			dvalid_out <= pop && (fifo_out.kind == CLR_ITEM_PIX);
			eol_out <= pop && (fifo_out.kind == CLR_ITEM_EOL);
			eof_out <= pop && (fifo_out.kind == CLR_ITEM_EOF);
			if (pop && fifo_out.kind == CLR_ITEM_PIX) begin
				data_out <= {8'h00, fifo_out.pix >> shamt};
			end
		end
	end

	chk_one_strobe: assert property (@(posedge clk) disable iff (sys_rst)
		$onehot0({dvalid_out, eol_out, eof_out}))
		else $error("two stream strobes high together");
	chk_top_byte: assert property (@(posedge clk) disable iff (sys_rst)
		dvalid_out |-> (data_out[31:24] == 8'h00))
		else $error("pixel top byte not zero");
	chk_eol_width: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(eol_out) |-> !pixel_clock ##1 (eol_out && pixel_clock) ##1 !eol_out)
		else $error("end of line not one pixel clock");
	chk_strobe_setup: assert property (@(posedge clk) disable iff (sys_rst)
		(dvalid_out && !pixel_clock) |=> pixel_clock && dvalid_out && $stable(data_out))
		else $error("pixel not held across pixel clock rise");
	chk_shift_mode: assert property (@(posedge clk) disable iff (sys_rst)
		(pop && fifo_out.kind == CLR_ITEM_PIX) |=>
		(data_out[23:0] == ($past(fifo_out.pix) >> $past(shamt))))
		else $error("pixel shift wrong");

	// region monitor, runs on each pixel clock rise
	logic tick;
	logic [CW-1:0] pcnt_q;
	logic [CW-1:0] lcnt_q;
	logic line_act_q;
	logic any_line_q;
	logic [CW-1:0] fp_q;
	logic [CW-1:0] lp_q;
	logic [CW-1:0] fl_q;
	logic [CW-1:0] ll_q;
	logic [CW-1:0] pix_total_q;
	logic [CW-1:0] line_total_q;
	logic [CW-1:0] first_pix_q;
	logic [CW-1:0] last_pix_q;
	logic [CW-1:0] first_line_q;
	logic [CW-1:0] last_line_q;
	logic roi_valid_q;
	logic bright;
	logic any_new;
	logic [CW-1:0] fl_new;
	logic [CW-1:0] ll_new;
	logic frame_done;

	assign tick = (phase_q == CLR_PH_RISE);
	assign bright = dvalid_out && (data_out[7:0] >= dark_level);
	assign any_new = any_line_q || line_act_q;
	assign fl_new = any_line_q ? fl_q : lcnt_q;
	assign ll_new = line_act_q ? lcnt_q : ll_q;
	assign frame_done = tick && eof_out;

	always_ff @(posedge clk) begin
		if (sys_rst || roi_restart) begin
			pcnt_q <= '0;
			lcnt_q <= '0;
			line_act_q <= 1'b0;
			any_line_q <= 1'b0;
			fp_q <= '1;
			lp_q <= '0;
			fl_q <= '0;
			ll_q <= '0;
		end else if (tick) begin
			if (dvalid_out) begin
				pcnt_q <= pcnt_q + 1'b1;
				if (bright) begin
					line_act_q <= 1'b1;
					if (pcnt_q < fp_q) begin
						fp_q <= pcnt_q;
					end
					if (pcnt_q > lp_q) begin
						lp_q <= pcnt_q;
					end
				end
			end else if (eol_out) begin
				pcnt_q <= '0;
				lcnt_q <= lcnt_q + 1'b1;
				line_act_q <= 1'b0;
				any_line_q <= any_new;
				fl_q <= fl_new;
				ll_q <= ll_new;
			end else if (eof_out) begin
				pcnt_q <= '0;
				lcnt_q <= '0;
				line_act_q <= 1'b0;
				any_line_q <= 1'b0;
				fp_q <= '1;
				lp_q <= '0;
			end
		end
	end

	// published values change only at a frame end or a restart, so reads stay coherent
	always_ff @(posedge clk) begin
		if (sys_rst || roi_restart) begin
			pix_total_q <= '0;
			line_total_q <= '0;
			first_pix_q <= '0;
			last_pix_q <= '0;
			first_line_q <= '0;
			last_line_q <= '0;
		end else if (frame_done) begin
			pix_total_q <= pcnt_q;
			line_total_q <= lcnt_q + 1'b1;
			first_pix_q <= any_new ? fp_q : '0;
			last_pix_q <= any_new ? lp_q : '0;
			first_line_q <= any_new ? fl_new : '0;
			last_line_q <= any_new ? ll_new : '0;
		end
	end

	// the frame-end set wins over a restart in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			roi_valid_q <= 1'b0;
		end else if (frame_done) begin
			roi_valid_q <= 1'b1;
		end else if (roi_restart) begin
			roi_valid_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			msg_data <= '0;
		end else if (msg_sel == `CLR_MSG_PIX_TOTAL) begin
			msg_data <= pix_total_q;
		end else if (msg_sel == `CLR_MSG_LINE_TOTAL) begin
			msg_data <= line_total_q;
		end else if (msg_sel == `CLR_MSG_FIRST_PIX) begin
			msg_data <= first_pix_q;
		end else if (msg_sel == `CLR_MSG_LAST_PIX) begin
			msg_data <= last_pix_q;
		end else if (msg_sel == `CLR_MSG_FIRST_LINE) begin
			msg_data <= first_line_q;
		end else if (msg_sel == `CLR_MSG_LAST_LINE) begin
			msg_data <= last_line_q;
		end else if (msg_sel == `CLR_MSG_STATUS) begin
			msg_data <= CW'({lost_word, roi_valid_q});
		end else begin
			msg_data <= '0;
		end
	end

	chk_totals_frame: assert property (@(posedge clk) disable iff (sys_rst || roi_restart)
		frame_done |=> (pix_total_q == $past(pcnt_q)) && (line_total_q == $past(lcnt_q) + 1'b1))
		else $error("frame totals not captured");
	chk_bounds_order: assert property (@(posedge clk) disable iff (sys_rst || roi_restart)
		(frame_done && any_new) |=> (first_line_q <= last_line_q) && (first_pix_q <= last_pix_q))
		else $error("active area bounds reversed");
	chk_msg_read: assert property (@(posedge clk) disable iff (sys_rst)
		(msg_sel == `CLR_MSG_LAST_LINE) |=> (msg_data == $past(last_line_q)))
		else $error("message read wrong value");
	chk_dark_hold: assert property (@(posedge clk) disable iff (sys_rst || roi_restart)
		(tick && dvalid_out && !bright) |=> $stable(fp_q) && $stable(lp_q))
		else $error("dark pixel moved bounds");
endmodule : clr_top
`default_nettype wire

// ### testbench/clr_cam_model.sv
// camera model: free running camera clock and four sliced lanes
`timescale 1ns/1ns
`default_nettype none
module clr_cam_model (
	// camera clock and lanes
	output logic cam_clk,
	output logic [3:0][6:0] cam_lane
);
	logic [27:0] word = 28'h0;
	// odd start offset keeps the camera clock unrelated to the system clock
	initial begin
		cam_clk = 1'b0;
		#13;
		forever #80 cam_clk = ~cam_clk;
	end
	// lane bit 6 is the first serial bit of each lane
	always_comb begin
		for (int l = 0; l < 4; l++) begin
			for (int b = 0; b < 7; b++) begin
				cam_lane[l][6-b] = word[7*l+b];
			end
		end
	end
	// ctl is {data valid, frame valid, line valid}
	task automatic put(input logic [2:0] ctl, input logic [23:0] pix);
		@(posedge cam_clk);
		#1 word = {1'b0, ctl, pix};
	endtask : put
	// blanking words carry inverted pixel bits so stale data is never reused
	task automatic send_frame(input int p, l, x0, x1, y0, y1, input logic [23:0] v);
		for (int y = 0; y < l; y++) begin
			for (int x = 0; x < p; x++) begin
				put(3'h7, (x >= x0 && x <= x1 && y >= y0 && y <= y1) ? v : 24'h0);
			end
			// two blanking words: the line end is resolved one word late
			repeat (2) put((y == l - 1) ? 3'h0 : 3'h2, ~word[23:0]);
		end
		put(3'h0, ~word[23:0]);
	endtask : send_frame
endmodule : clr_cam_model
`default_nettype wire

// ### testbench/tb_camera_link_input_roi_monitor.sv
// self-checking bench of the camera link receiver and region monitor
`timescale 1ns/1ns
`default_nettype none
`include "clr_regs.svh"
module tb_camera_link_input_roi_monitor;
	typedef struct {int sh, p, l, x0, x1, y0, y1;} clr_row_t;
	localparam logic [23:0] VAL = 24'hABCFF0;
	// shift code, pixels, lines, bright box x0..x1, y0..y1
	clr_row_t rows [4] = '{'{0, 6, 4, 1, 4, 1, 2}, '{1, 5, 3, 0, 4, 0, 2},
		'{2, 7, 5, 2, 2, 3, 4}, '{3, 4, 2, 0, 3, 1, 1}};
	clr_row_t cur;
	logic clk = 1'b0;
	logic sys_rst, cam_clk, stream_hold, roi_restart, pixel_clock;
	logic dvalid_out, eol_out, eof_out, lost_word, hf_pclk, hf_dv;
	logic [3:0][6:0] cam_lane;
	logic [31:0] data_out;
	logic [1:0] shift_sel;
	logic [7:0] dark_level;
	logic [2:0] msg_sel;
	logic [15:0] msg_data;
	int x, y, npix, nlines, neof, tot;
	int hf_pix = 0;
	int err_total = 0;
	int check_count = 0;
	always #20 clk = ~clk;
	clr_cam_model cam (.cam_clk(cam_clk), .cam_lane(cam_lane));
	clr_top #(.HIGH_FREQ(1'b0)) DUT (.clk(clk), .sys_rst(sys_rst), .cam_clk(cam_clk),
		.cam_lane(cam_lane), .stream_hold(stream_hold), .pixel_clock(pixel_clock),
		.dvalid_out(dvalid_out), .eol_out(eol_out), .eof_out(eof_out), .data_out(data_out),
		.lost_word(lost_word), .shift_sel(shift_sel), .dark_level(dark_level),
		.roi_restart(roi_restart), .msg_sel(msg_sel), .msg_data(msg_data));
	clr_top #(.HIGH_FREQ(1'b1)) DUT_HF (.clk(clk), .sys_rst(sys_rst), .cam_clk(cam_clk),
		.cam_lane(cam_lane), .stream_hold(stream_hold), .pixel_clock(hf_pclk),
		.dvalid_out(hf_dv), .eol_out(), .eof_out(), .data_out(), .lost_word(),
		.shift_sel(shift_sel), .dark_level(dark_level), .roi_restart(roi_restart),
		.msg_sel(msg_sel), .msg_data());
	task automatic check(input string n, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, exp, seen);
		end
	endtask : check
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	function automatic logic [31:0] exp_pix(input int px, py);
		logic [23:0] v;
		v = (px >= cur.x0 && px <= cur.x1 && py >= cur.y0 && py <= cur.y1) ? VAL : 24'h0;
		case (cur.sh)
			1: v = v >> `CLR_SHAMT_10BIT;
			2: v = v >> `CLR_SHAMT_12BIT;
			default: v = v;
		endcase
		return {8'h00, v};
	endfunction : exp_pix
	// downstream samples on the pixel clock rise
	always @(posedge pixel_clock) begin
		check("one strobe", {31'h0, $countones({dvalid_out, eol_out, eof_out}) <= 1}, 32'h1);
		if (dvalid_out === 1'b1) begin
			check("pixel", data_out, exp_pix(x, y));
			x++;
			npix++;
		end
		if (eol_out === 1'b1) begin
			nlines++;
			x = 0;
			y++;
		end
		if (eof_out === 1'b1) begin
			neof++;
			x = 0;
			y = 0;
		end
	end
	always @(posedge hf_pclk) begin
		if (hf_dv === 1'b1) hf_pix++;
	end
	task automatic rd(input logic [2:0] s, input logic [15:0] e, input string n);
		msg_sel = s;
		@(posedge clk);
		#1 check(n, {16'h0, msg_data}, {16'h0, e});
	endtask : rd
	// outputs are checked while reset is still held
	task automatic do_reset();
		sys_rst = 1'b1;
		repeat (6) @(posedge clk);
		#1 check("reset outs", {11'h0, pixel_clock, dvalid_out, eol_out, eof_out, lost_word,
			msg_data}, 32'h0);
		sys_rst = 1'b0;
	endtask : do_reset
	initial begin
		#200000;
		err_total++;
		wrap_up();
	end
	initial begin
		stream_hold = 1'b0;
		shift_sel = 2'h0;
		dark_level = `CLR_DARK_DEFAULT;
		roi_restart = 1'b0;
		msg_sel = 3'h0;
		tot = 0;
		cur = rows[0];
		do_reset();
		repeat (3) @(posedge cam_clk);
		@(posedge clk);
		#1;
		foreach (rows[i]) begin
			cur = rows[i];
			shift_sel = 2'(cur.sh);
			roi_restart = 1'b1;
			repeat (2) @(posedge clk);
			#1 roi_restart = 1'b0;
			x = 0;
			y = 0;
			npix = 0;
			nlines = 0;
			neof = 0;
			tot += cur.p * cur.l;
			cam.send_frame(cur.p, cur.l, cur.x0, cur.x1, cur.y0, cur.y1, VAL);
			for (int t = 0; t < 400 && neof == 0; t++) @(posedge clk);
			repeat (4) @(posedge clk);
			#1 check("pixels", npix, cur.p * cur.l);
			check("line ends", nlines, cur.l - 1);
			check("frame ends", neof, 1);
			rd(`CLR_MSG_PIX_TOTAL, 16'(cur.p), "pix total");
			rd(`CLR_MSG_LINE_TOTAL, 16'(cur.l), "line total");
			rd(`CLR_MSG_FIRST_PIX, 16'(cur.x0), "first pix");
			rd(`CLR_MSG_LAST_PIX, 16'(cur.x1), "last pix");
			rd(`CLR_MSG_FIRST_LINE, 16'(cur.y0), "first line");
			rd(`CLR_MSG_LAST_LINE, 16'(cur.y1), "last line");
			rd(`CLR_MSG_STATUS, 16'h0001, "status");
		end
		check("fast variant", hf_pix, tot);
		// a threshold above the pixel byte leaves no active area
		dark_level = 8'hF1;
		roi_restart = 1'b1;
		repeat (2) @(posedge clk);
		#1 roi_restart = 1'b0;
		x = 0;
		y = 0;
		neof = 0;
		cam.send_frame(cur.p, cur.l, cur.x0, cur.x1, cur.y0, cur.y1, VAL);
		for (int t = 0; t < 400 && neof == 0; t++) @(posedge clk);
		repeat (4) @(posedge clk);
		#1 check("dark frame ends", neof, 1);
		rd(`CLR_MSG_PIX_TOTAL, 16'(cur.p), "dark pix total");
		rd(`CLR_MSG_FIRST_PIX, 16'h0000, "dark first pix");
		rd(`CLR_MSG_LAST_PIX, 16'h0000, "dark last pix");
		rd(`CLR_MSG_LAST_LINE, 16'h0000, "dark last line");
		rd(3'h7, 16'h0000, "unused select");
		dark_level = `CLR_DARK_DEFAULT;
		// a held stream cannot drain, so a long dark line overruns the fifo
		stream_hold = 1'b1;
		cur.x0 = 1;
		cur.x1 = 0;
		cam.send_frame(12, 1, 1, 0, 0, 0, VAL);
		#1 check("held strobes", {31'h0, dvalid_out}, 32'h0);
		check("lost word", {31'h0, lost_word}, 32'h1);
		@(posedge clk);
		#1 stream_hold = 1'b0;
		repeat (60) @(posedge clk);
		#1 do_reset();
		wrap_up();
	end
endmodule : tb_camera_link_input_roi_monitor
`default_nettype wire
